// ### shared/cmp_timer_consts.svh
`ifndef CMP_TIMER_CONSTS_SVH
`define CMP_TIMER_CONSTS_SVH
// Register addresses
`define ADDR_CONTROL      16'hFFB6
`define ADDR_CTRL_STATUS  16'hFFB7
`define ADDR_COUNT_HIGH   16'hFFB8
`define ADDR_COUNT_LOW    16'hFFB9
`define ADDR_COMPARE_HIGH 16'hFFBA
`define ADDR_COMPARE_LOW  16'hFFBB
`define ADDR_CLOCK_STOP   16'hFFFA
`define ADDR_IRQ_STATUS   16'hFFBC
// Reset values
`define RST_COUNT         8'h00
`define RST_COMPARE       8'hFF
`define RST_CONTROL       8'h00
`define RST_CTRL_STATUS   8'h00
`define RST_CLOCK_STOP    8'hFF
`define BYTE_ONES         8'hFF
// Control register fields
`define CTL_HIGH_LEVEL    7
`define CTL_HIGH_SEL_TOP  6
`define CTL_HIGH_SEL_LO   4
`define CTL_LOW_LEVEL     3
`define CTL_LOW_SEL_TOP   2
`define CTL_LOW_SEL_LO    0
// Control/status fields
`define CS_HIGH_OVF       7
`define CS_HIGH_CMF       6
`define CS_HIGH_OVIE      5
`define CS_HIGH_CCLR      4
`define CS_LOW_OVF        3
`define CS_LOW_CMF        2
`define CS_LOW_OVIE       1
`define CS_LOW_CCLR       0
// Clock stop bit for this timer
`define CKSTP_TIMER_BIT   2
// Clock select codes
`define SEL_EVENT         3'h0
`define SEL_DIV32         3'h4
`define SEL_DIV16         3'h5
`define SEL_DIV4          3'h6
`define SEL_SUB4          3'h7
// Prescaler divisions
`define DIV_SUB_RATIO     8'h08
`endif

// ### shared/cmp_timer_pkg.sv
package cmp_timer_pkg;
    // Clock select field
    typedef logic [2:0] clk_sel_t;
    // Byte register
    typedef logic [7:0] byte_t;
endpackage

// ### shared/tick_if.sv
`timescale 1ns/1ps
// Prescaler ticks shared between prescaler and timer core
interface tick_if;
    logic div32;
    logic div16;
    logic div4;
    logic sub4;
    modport src (output div32, output div16, output div4, output sub4);
    modport dst (input div32, input div16, input div4, input sub4);
endinterface

// ### core/tick_prescaler.sv
`timescale 1ns/1ps
`include "cmp_timer_consts.svh"
module tick_prescaler
    import cmp_timer_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_run,
    tick_if.src       ticks
);
    typedef struct packed {
        logic [4:0] main_cnt;
        logic [7:0] sub_cnt;
        logic [1:0] sub4_cnt;
    } pre_state_t;

    pre_state_t state_reg;
    pre_state_t state_next;
    logic       sub_tick;

    // Sub-clock stand-in tick and divided ticks
    assign sub_tick    = (state_reg.sub_cnt == (`DIV_SUB_RATIO - 8'h01));
    assign ticks.div4  = i_run && (state_reg.main_cnt[1:0] == 2'h3);
    assign ticks.div16 = i_run && (state_reg.main_cnt[3:0] == 4'hF);
    assign ticks.div32 = i_run && (state_reg.main_cnt == 5'h1F);
    assign ticks.sub4  = i_run && sub_tick && (state_reg.sub4_cnt == 2'h3);

    // Free-running dividers, held while the module clock is stopped
    always_comb
    begin
        state_next = state_reg;
        if (i_run)
        begin
            state_next.main_cnt = state_reg.main_cnt + 5'h01;
            state_next.sub_cnt  = sub_tick ? 8'h00 : state_reg.sub_cnt + 8'h01;
            if (sub_tick)
            begin
                state_next.sub4_cnt = state_reg.sub4_cnt + 2'h1;
            end
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule

// ### core/event_sync.sv
`timescale 1ns/1ps
module event_sync
    import cmp_timer_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    input  wire logic i_rise_edge,
    output logic      o_edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // Edge detector looks only at the second stage and its delayed copy
    assign o_edge = i_rise_edge ? (state_reg.sync && !state_reg.prev)
                                : (!state_reg.sync && state_reg.prev);

    // Two-stage synchroniser then delay stage
    always_comb
    begin
        state_next      = state_reg;
        state_next.meta = i_pin;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule

// ### core/cmp_timer.sv
`timescale 1ns/1ps
`include "cmp_timer_consts.svh"
// Function
// - Two byte counters cascade into sixteen bits
// - Select top zero gives sixteen-bit mode
// - Select top one gives independent halves
// - Sixteen-bit pairs pass through temporary byte
// - Counters reset to zero, read/write
// - Compare bytes reset to ones, read/write
// - Sixteen-bit clear on match by high enable
// - Eight-bit clear on match per half
// - Sixteen-bit wrap sets high overflow, request
// - Eight-bit wrap sets own overflow, request
// - Sixteen-bit match sets high flag, request
// - Eight-bit match sets own flag, request
// - Sixteen-bit matches toggle high output pin
// - Eight-bit matches toggle own output pin
// - Control register write-only, field layout fixed
// - High level bit drives pin at once
// - Event pin feeds only low counter
// - Compare pair is high then low byte
// - Low select: event or four internal clocks
// - High select: cascade or four internal clocks
// - Flags cleared by read one, write zero; code clears on any write of zero, no read needed first
// - Control/status layout, resets to zero
module cmp_timer
    import cmp_timer_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    input  wire logic        i_event_in_pin,
    input  wire logic        i_event_rise,
    input  wire logic        i_high_irq_enable,
    input  wire logic        i_low_irq_enable,
    output logic             o_high_toggle_pin,
    output logic             o_low_toggle_pin,
    output logic             o_high_irq_request,
    output logic             o_low_irq_request,
    output logic             o_high_irq,
    output logic             o_low_irq
);
    typedef struct packed {
        byte_t count_high;
        byte_t count_low;
        byte_t compare_high;
        byte_t compare_low;
        byte_t control_reg;
        byte_t ctrl_status_reg;
        byte_t clock_stop_reg_one;
        byte_t temp;
        logic  high_seen;
        logic  low_seen;
        logic  high_level;
        logic  low_level;
        logic  high_req;
        logic  low_req;
        byte_t rdata;
    } tmr_state_t;

    tmr_state_t state_reg;
    tmr_state_t state_next;
    tick_if     ticks ();
    logic       event_edge;
    logic       run;
    logic       mode16;
    clk_sel_t   low_clock_select;
    clk_sel_t   high_clock_select;
    logic       low_tick;
    logic       high_tick;
    logic       low_wrap;
    logic       match16;
    logic       match_high;
    logic       match_low;
    logic       wr_hit;
    logic       rd_hit;
    logic       low_ovf_hw;

    // Select an internal tick for a clock select code
    function automatic logic pick_tick(input clk_sel_t sel, input logic d32, input logic d16,
                                       input logic d4, input logic s4);
        case (sel)
            `SEL_DIV32: pick_tick = d32;
            `SEL_DIV16: pick_tick = d16;
            `SEL_DIV4:  pick_tick = d4;
            `SEL_SUB4:  pick_tick = s4;
            default:    pick_tick = 1'b0;
        endcase
    endfunction

    // Address compare used only for the write strobe; reads decode i_addr in a case
    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    tick_prescaler u_prescaler (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (run),
        .ticks   (ticks)
    );

    // Event pin only to low half
    event_sync u_event_sync (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_pin       (i_event_in_pin),
        .i_rise_edge (i_event_rise),
        .o_edge      (event_edge)
    );

    // Mode and clock selection decode
    assign run               = !state_reg.clock_stop_reg_one[`CKSTP_TIMER_BIT] ? 1'b0 : 1'b1;
    assign low_clock_select  = state_reg.control_reg[`CTL_LOW_SEL_TOP:`CTL_LOW_SEL_LO];
    assign high_clock_select = state_reg.control_reg[`CTL_HIGH_SEL_TOP:`CTL_HIGH_SEL_LO];
    assign mode16            = !state_reg.control_reg[`CTL_HIGH_SEL_TOP];

    assign low_tick = run && ((low_clock_select == `SEL_EVENT) ? event_edge
                    : pick_tick(low_clock_select, ticks.div32, ticks.div16, ticks.div4, ticks.sub4));
    assign low_wrap = low_tick && (state_reg.count_low == `BYTE_ONES);
    // Cascade on low wrap same cycle
    assign high_tick = mode16 ? low_wrap
                     : run && pick_tick(high_clock_select, ticks.div32, ticks.div16, ticks.div4, ticks.sub4);

    assign match16    = {state_reg.count_high, state_reg.count_low}
                     == {state_reg.compare_high, state_reg.compare_low};
    assign match_high = mode16 ? match16 : (state_reg.count_high == state_reg.compare_high);
    assign match_low  = !mode16 && (state_reg.count_low == state_reg.compare_low);

    assign wr_hit = i_wr;
    assign rd_hit = i_rd;

    // Pins, requests and read data from flip-flops; interrupts are requests gated by the enable inputs
    assign o_rdata            = state_reg.rdata;
    assign o_high_toggle_pin  = state_reg.high_level;
    assign o_low_toggle_pin   = state_reg.low_level;
    assign o_high_irq_request = state_reg.high_req;
    assign o_low_irq_request  = state_reg.low_req;
    assign o_high_irq         = state_reg.high_req && i_high_irq_enable;
    assign o_low_irq          = state_reg.low_req && i_low_irq_enable;

    // Next-state logic for counters, flags, pins and bus
    always_comb
    begin
        logic high_ovf;
        logic low_ovf;
        logic high_match_ev;
        logic low_match_ev;
        high_ovf      = 1'b0;
        low_ovf       = 1'b0;
        high_match_ev = 1'b0;
        low_match_ev  = 1'b0;
        state_next    = state_reg;
        state_next.rdata = 8'h00;

        // Byte counters advance, cascaded or alone
        if (low_tick)
        begin
            state_next.count_low = state_reg.count_low + 8'h01;
        end
        if (high_tick)
        begin
            state_next.count_high = state_reg.count_high + 8'h01;
        end

        if (mode16)
        begin
            high_ovf = low_wrap && (state_reg.count_high == `BYTE_ONES);
        end
        else
        begin
            high_ovf = high_tick && (state_reg.count_high == `BYTE_ONES);
            low_ovf  = low_wrap;
        end

        // Match events fire when the compare becomes true
        high_match_ev = match_high && !state_reg.high_seen;
        low_match_ev  = match_low && !state_reg.low_seen;
        state_next.high_seen = match_high;
        state_next.low_seen  = match_low;

        if (high_match_ev && state_reg.ctrl_status_reg[`CS_HIGH_CCLR])
        begin
            state_next.count_high = `RST_COUNT;
            if (mode16)
            begin
                state_next.count_low = `RST_COUNT;
            end
        end
        if (low_match_ev && state_reg.ctrl_status_reg[`CS_LOW_CCLR])
        begin
            state_next.count_low = `RST_COUNT;
        end

        // Bus reads
        if (rd_hit)
        begin
            case (i_addr)
                `ADDR_CTRL_STATUS:
                begin
                    state_next.rdata = state_reg.ctrl_status_reg;
                end
                // Sixteen-bit high read latches low into temp
                `ADDR_COUNT_HIGH:
                begin
                    state_next.rdata = state_reg.count_high;
                    if (mode16)
                    begin
                        state_next.temp = state_reg.count_low;
                    end
                end
                `ADDR_COUNT_LOW:    state_next.rdata = mode16 ? state_reg.temp : state_reg.count_low;
                `ADDR_COMPARE_HIGH:
                begin
                    state_next.rdata = state_reg.compare_high;
                    if (mode16)
                    begin
                        state_next.temp = state_reg.compare_low;
                    end
                end
                `ADDR_COMPARE_LOW:  state_next.rdata = mode16 ? state_reg.temp : state_reg.compare_low;
                `ADDR_CLOCK_STOP:   state_next.rdata = state_reg.clock_stop_reg_one;
                `ADDR_IRQ_STATUS:   state_next.rdata = {6'h00, state_reg.high_req, state_reg.low_req};
                default:            state_next.rdata = 8'h00;
            endcase
        end

        // Flags: write zero clears, write one keeps
        if (wr_hit && hit(i_addr, `ADDR_CTRL_STATUS))
        begin
            state_next.ctrl_status_reg[`CS_HIGH_OVIE] = i_wdata[`CS_HIGH_OVIE];
            state_next.ctrl_status_reg[`CS_HIGH_CCLR] = i_wdata[`CS_HIGH_CCLR];
            state_next.ctrl_status_reg[`CS_LOW_OVIE]  = i_wdata[`CS_LOW_OVIE];
            state_next.ctrl_status_reg[`CS_LOW_CCLR]  = i_wdata[`CS_LOW_CCLR];
            state_next.ctrl_status_reg[`CS_HIGH_OVF]  = state_reg.ctrl_status_reg[`CS_HIGH_OVF] & i_wdata[`CS_HIGH_OVF];
            state_next.ctrl_status_reg[`CS_HIGH_CMF]  = state_reg.ctrl_status_reg[`CS_HIGH_CMF] & i_wdata[`CS_HIGH_CMF];
            state_next.ctrl_status_reg[`CS_LOW_OVF]   = state_reg.ctrl_status_reg[`CS_LOW_OVF] & i_wdata[`CS_LOW_OVF];
            state_next.ctrl_status_reg[`CS_LOW_CMF]   = state_reg.ctrl_status_reg[`CS_LOW_CMF] & i_wdata[`CS_LOW_CMF];
        end
        if (wr_hit && hit(i_addr, `ADDR_IRQ_STATUS))
        begin
            state_next.high_req = state_reg.high_req & i_wdata[1];
            state_next.low_req  = state_reg.low_req & i_wdata[0];
        end

        // Counter, compare and clock stop writes; counter and compare go via temp in sixteen-bit mode
        if (wr_hit)
        begin
            case (i_addr)
                `ADDR_COUNT_HIGH:
                begin
                    if (mode16)
                    begin
                        state_next.temp = i_wdata;
                    end
                    else
                    begin
                        state_next.count_high = i_wdata;
                    end
                end
                `ADDR_COUNT_LOW:
                begin
                    state_next.count_low = i_wdata;
                    if (mode16)
                    begin
                        state_next.count_high = state_reg.temp;
                    end
                end
                `ADDR_COMPARE_HIGH:
                begin
                    if (mode16)
                    begin
                        state_next.temp = i_wdata;
                    end
                    else
                    begin
                        state_next.compare_high = i_wdata;
                    end
                end
                `ADDR_COMPARE_LOW:
                begin
                    state_next.compare_low = i_wdata;
                    if (mode16)
                    begin
                        state_next.compare_high = state_reg.temp;
                    end
                end
                `ADDR_CLOCK_STOP: state_next.clock_stop_reg_one = i_wdata;
                default:          ;
            endcase
        end

        // Overflow sets flag, request only if its enable is set; match sets flag and request together
        if (high_ovf)
        begin
            state_next.ctrl_status_reg[`CS_HIGH_OVF] = 1'b1;
            if (state_reg.ctrl_status_reg[`CS_HIGH_OVIE])
            begin
                state_next.high_req = 1'b1;
            end
        end
        if (low_ovf)
        begin
            state_next.ctrl_status_reg[`CS_LOW_OVF] = 1'b1;
            if (state_reg.ctrl_status_reg[`CS_LOW_OVIE])
            begin
                state_next.low_req = 1'b1;
            end
        end
        if (high_match_ev)
        begin
            state_next.ctrl_status_reg[`CS_HIGH_CMF] = 1'b1;
            state_next.high_req                      = 1'b1;
        end
        if (low_match_ev)
        begin
            state_next.ctrl_status_reg[`CS_LOW_CMF] = 1'b1;
            state_next.low_req                      = 1'b1;
        end

        if (high_match_ev)
        begin
            state_next.high_level = !state_reg.high_level;
        end
        if (low_match_ev)
        begin
            state_next.low_level = !state_reg.low_level;
        end

        // Level bit overrides pin at once
        if (wr_hit && hit(i_addr, `ADDR_CONTROL))
        begin
            state_next.control_reg = i_wdata;
            state_next.high_level  = i_wdata[`CTL_HIGH_LEVEL];
            state_next.low_level   = i_wdata[`CTL_LOW_LEVEL];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg                    <= '0;
            state_reg.count_high         <= `RST_COUNT;
            state_reg.count_low          <= `RST_COUNT;
            state_reg.compare_high       <= `RST_COMPARE;
            state_reg.compare_low        <= `RST_COMPARE;
            state_reg.control_reg        <= `RST_CONTROL;
            state_reg.ctrl_status_reg    <= `RST_CTRL_STATUS;
            state_reg.clock_stop_reg_one <= `RST_CLOCK_STOP;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Assertions
    a_wrap_sets_ovf: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!mode16 && low_wrap) |=> state_reg.ctrl_status_reg[`CS_LOW_OVF])
        else $error("low wrap did not set overflow");
    a_cascade_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (mode16 && low_wrap && !wr_hit && !match16 && state_reg.count_high != `BYTE_ONES)
        |=> state_reg.count_high == $past(state_reg.count_high) + 8'h01)
        else $error("high byte did not follow low wrap");
    a_match_flag_req: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (match_high && !state_reg.high_seen) |=> (state_reg.ctrl_status_reg[`CS_HIGH_CMF] && state_reg.high_req))
        else $error("match did not set flag and request");
    a_low_match: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (match_low && !state_reg.low_seen) |=> state_reg.ctrl_status_reg[`CS_LOW_CMF])
        else $error("low match flag missing");
    a_level_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (wr_hit && i_addr == `ADDR_CONTROL) |=> o_high_toggle_pin == $past(i_wdata[`CTL_HIGH_LEVEL]))
        else $error("high pin not set by level write");
    a_match_toggle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (match_low && !state_reg.low_seen && !(wr_hit && i_addr == `ADDR_CONTROL))
        |=> o_low_toggle_pin != $past(o_low_toggle_pin))
        else $error("low pin did not toggle");
    a_flag_hw_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!state_reg.ctrl_status_reg[`CS_LOW_OVF] && !low_ovf_hw) |=> !state_reg.ctrl_status_reg[`CS_LOW_OVF])
        else $error("overflow flag set without wrap");
    a_low_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (match_low && !state_reg.low_seen && state_reg.ctrl_status_reg[`CS_LOW_CCLR] && !wr_hit)
        |=> state_reg.count_low == `RST_COUNT)
        else $error("low counter not cleared on match");
    a_event_only_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!mode16 && high_tick) |-> (ticks.div32 || ticks.div16 || ticks.div4 || ticks.sub4))
        else $error("event reached high counter");

    // Eight-bit low wrap, the only way the low overflow flag may rise
    assign low_ovf_hw = !mode16 && low_wrap;

    c_mode16_wrap: cover property (@(posedge i_mclk) disable iff (!i_rst_n) mode16 && low_wrap);
    c_high_match: cover property (@(posedge i_mclk) disable iff (!i_rst_n) match_high && !state_reg.high_seen);
    c_low_event: cover property (@(posedge i_mclk) disable iff (!i_rst_n) low_tick && low_clock_select == `SEL_EVENT);
endmodule

// ### verif/event_source.sv
`timescale 1ns/1ps
// Drives the event pin; each pulse gives one rising and one falling edge
module event_source (
    output logic o_pin,
    input  wire logic i_mclk
);
    initial o_pin = 1'b0;
    // Pulse train, then idle long enough for the synchroniser to settle
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge i_mclk);
            o_pin <= 1'b1;
            repeat (4) @(posedge i_mclk);
            o_pin <= 1'b0;
        end
        repeat (8) @(posedge i_mclk);
    endtask
endmodule

// ### verif/cmp_timer_tb_top.sv
`timescale 1ns/1ps
module cmp_timer_tb_top
    import cmp_timer_pkg::*;
    ;
    logic        i_mclk, i_rst_n, i_wr, i_rd, i_event_rise, i_high_irq_enable, i_low_irq_enable;
    logic [15:0] i_addr;
    byte_t       i_wdata, o_rdata, r, exp_q[$];
    logic        ev_pin, hpin, lpin, hreq, lreq, hirq, lirq, rd_seen;
    int          errors, checked, cycles, seed;
    event_source ev_u (.o_pin(ev_pin), .i_mclk(i_mclk));
    cmp_timer dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_in_pin(ev_pin), .i_event_rise(i_event_rise),
        .i_high_irq_enable(i_high_irq_enable), .i_low_irq_enable(i_low_irq_enable),
        .o_high_toggle_pin(hpin), .o_low_toggle_pin(lpin), .o_high_irq_request(hreq),
        .o_low_irq_request(lreq), .o_high_irq(hirq), .o_low_irq(lirq));
    // Clock at 50 ns
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic chk(input string n, input byte_t e, input byte_t g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Pin levels compared as single bits
    task automatic chk_pin(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input byte_t d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    // Read notes its expectation; the watcher compares one cycle later
    task automatic rd(input logic [15:0] a, input byte_t e);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask
    // Read data watcher and hang guard
    always @(posedge i_mclk)
    begin
        rd_seen <= i_rd;
        if (rd_seen === 1'b1)
            chk("rdata", exp_q.pop_front(), o_rdata);
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            errors++;
            test_done();
        end
    end
    // Main sequence: reset values, 16-bit mode, then 8-bit mode
    initial
    begin
        seed = 98;
        i_rst_n = 1'b0;
        {i_addr, i_wdata, i_wr, i_rd, i_high_irq_enable} = '0;
        i_event_rise = 1'b1;
        i_low_irq_enable = 1'b1;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        i_event_rise <= 1'($random(seed));
        @(posedge i_mclk);
        rd(16'hFFB8, 8'h00);
        rd(16'hFFB9, 8'h00);
        rd(16'hFFBA, 8'hFF);
        rd(16'hFFBB, 8'hFF);
        rd(16'hFFB7, 8'h00);
        rd(16'hFFB6, 8'h00);
        rd(16'hFFFA, 8'hFF);
        rd(16'hFF00, 8'h00);
        // High byte first into the shared temporary byte
        wr(16'hFFBA, 8'h13);
        wr(16'hFFBB, 8'h02);
        wr(16'hFFB7, 8'h10);
        wr(16'hFFB8, 8'h12);
        wr(16'hFFB9, 8'hFF);
        ev_u.pulses(1);
        rd(16'hFFB8, 8'h13);
        rd(16'hFFB9, 8'h00);
        ev_u.pulses(3);
        rd(16'hFFB8, 8'h00);
        rd(16'hFFB9, 8'h01);
        chk_pin("hpin", 1'b1, hpin);
        chk_pin("hreq", 1'b1, hreq);
        chk_pin("hirq", 1'b0, hirq);
        i_high_irq_enable <= 1'b1;
        @(posedge i_mclk);
        chk_pin("hirq", 1'b1, hirq);
        rd(16'hFFB7, 8'h50);
        wr(16'hFFB7, 8'h10);
        rd(16'hFFB7, 8'h10);
        wr(16'hFFB7, 8'hD0);
        rd(16'hFFB7, 8'h10);
        wr(16'hFFB8, 8'hFF);
        wr(16'hFFB9, 8'hFF);
        ev_u.pulses(1);
        rd(16'hFFB7, 8'h90);
        wr(16'hFFB6, 8'h00);
        chk_pin("hpin", 1'b0, hpin);
        wr(16'hFFB6, 8'h80);
        chk_pin("hpin", 1'b1, hpin);
        // Independent halves, low half on events
        wr(16'hFFB6, 8'h78);
        chk_pin("lpin", 1'b1, lpin);
        chk_pin("hpin", 1'b0, hpin);
        wr(16'hFFB6, 8'h70);
        chk_pin("lpin", 1'b0, lpin);
        wr(16'hFFB7, 8'h03);
        wr(16'hFFB8, 8'h00);
        r = byte_t'($random(seed)) | 8'h80;
        wr(16'hFFBA, r);
        rd(16'hFFBA, r);
        wr(16'hFFBB, 8'h03);
        wr(16'hFFB9, 8'h00);
        ev_u.pulses(4);
        rd(16'hFFB9, 8'h01);
        chk_pin("lpin", 1'b1, lpin);
        chk_pin("lirq", 1'b1, lirq);
        rd(16'hFFB7, 8'h07);
        wr(16'hFFB7, 8'h02);
        wr(16'hFFBC, 8'h00);
        chk_pin("lreq", 1'b0, lreq);
        wr(16'hFFB9, 8'hFE);
        ev_u.pulses(2);
        rd(16'hFFB7, 8'h0A);
        rd(16'hFFBC, 8'h01);
        @(posedge i_mclk);
        test_done();
    end
endmodule
